// file: hw/tscd_pkg.sv
// Constants and types of the trigger select block
package tscd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indexes; byte address is four times
    localparam logic [15:0] IDX_BOARD_COMMAND = 16'h0000;
    localparam logic [15:0] IDX_EXT_CLOCK_DIVIDER = 16'h4E48;
    localparam logic [15:0] IDX_TRIGGER_MODE_SELECT = 16'h9C40;
    localparam logic [15:0] IDX_TRIGGER_CONNECTOR_DIRECTION = 16'h9CA4;
    localparam logic [15:0] IDX_TRIGGER_INPUT_TERMINATION = 16'h9CAE;
    localparam logic [15:0] IDX_TRIGGER_STATUS = 16'h9D08;
    localparam logic [15:0] IDX_PULSE_LENGTH_LIMIT = 16'hABE0;

    ////////////////////////////////////////////////////////////////////////
    // Command codes
    localparam logic [31:0] CMD_START = 32'h0000_0001;
    localparam logic [31:0] CMD_STOP = 32'h0000_0002;
    localparam logic [31:0] FORCE_TRIGGER_CMD = 32'h0000_0010;

    ////////////////////////////////////////////////////////////////////////
    // Trigger mode codes
    localparam logic [31:0] FREE_RUN_MODE = 32'h0000_0000;
    localparam logic [31:0] RISING_EDGE_MODE = 32'h0000_4E20;
    localparam logic [31:0] FALLING_EDGE_MODE = 32'h0000_4E2A;
    localparam logic [31:0] ANY_EDGE_MODE = 32'h0000_4E3E;
    localparam logic [31:0] LONG_HIGH_PULSE_MODE = 32'h0000_4E21;
    localparam logic [31:0] SHORT_HIGH_PULSE_MODE = 32'h0000_4E22;
    localparam logic [31:0] LONG_LOW_PULSE_MODE = 32'h0000_4E23;
    localparam logic [31:0] SHORT_LOW_PULSE_MODE = 32'h0000_4E24;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and field limits
    localparam logic [31:0] RST_BOARD_COMMAND = 32'h0000_0000;
    localparam logic [10:0] RST_EXT_CLOCK_DIVIDER = 11'h001;
    localparam logic [31:0] RST_TRIGGER_MODE_SELECT = 32'h0000_0000;
    localparam logic RST_TRIGGER_CONNECTOR_DIRECTION = 1'b0;
    localparam logic RST_TRIGGER_INPUT_TERMINATION = 1'b0;
    localparam logic [7:0] RST_PULSE_LENGTH_LIMIT = 8'h02;
    localparam logic [7:0] PULSE_LENGTH_MIN = 8'h02;
    localparam logic [7:0] PULSE_LENGTH_MAX = 8'hFF;
    localparam int DIV_W = 11;

    ////////////////////////////////////////////////////////////////////////
    // Status field positions
    localparam int STAT_ARMED_BIT = 0;
    localparam int STAT_SETUP_BIT = 1;
    localparam int STAT_REC_BIT = 2;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int SETUP_TIME_NS = 20;
    localparam int SETUP_CYCLES = (SETUP_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] SETUP_CNT_LAST = 4'(SETUP_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    // Acquisition sequence
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_ARMED,
        ST_REC
    } tscd_state_t;

    // Allowed divider factors
    function automatic logic div_allowed(input logic [31:0] v);
        case (v)
            32'd1, 32'd2, 32'd4, 32'd8, 32'd10, 32'd16, 32'd20, 32'd40,
            32'd50, 32'd80, 32'd100, 32'd200, 32'd400, 32'd500, 32'd800,
            32'd1000, 32'd2000: div_allowed = 1'b1;
            default: div_allowed = 1'b0;
        endcase
    endfunction : div_allowed

endpackage : tscd_pkg

// file: hw/tscd_clk_div.sv
// External clock divider, one-cycle sample enable
`timescale 1ns/1ps
module tscd_clk_div (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ext_clk_i,
    input wire logic [10:0] div_i,
    output logic tick_o
);

    logic ext_q;
    logic [10:0] cnt;
    logic ext_rise;

    assign ext_rise = ext_clk_i & ~ext_q;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ext_q <= 1'b0;
        end else begin
            ext_q <= ext_clk_i;
        end
    end

    // One tick every div_i external rising edges
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cnt <= 11'h000;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (ext_rise) begin
                if (cnt >= div_i - 11'h001) begin
                    cnt <= 11'h000;
                    tick_o <= 1'b1; // [RULE1]
                end else begin
                    cnt <= cnt + 11'h001;
                end
            end
        end
    end

endmodule : tscd_clk_div

// file: hw/tscd_top.sv
// Trigger select and clock divider, AHB-Lite registers
// Operation
// RULE1 - Divide external clock by listed fixed factors
// RULE2 - Divided external clock is the sample clock
// RULE3 - External clock must exceed one megasample
// RULE4 - Free run mode starts after setup time
// RULE5 - Force trigger works only while waiting
// RULE6 - Direction zero leaves connector driver disabled
// RULE7 - Direction one outputs internal trigger events
// RULE8 - Internal modes drive active high acquisition mark
// RULE9 - External modes force connector to input
// RULE10 - Rising edge mode triggers on rises
// RULE11 - Falling edge mode triggers on falls
// RULE12 - Any edge mode triggers on both edges
// RULE13 - Long high pulse mode triggers
// RULE14 - Short high pulse mode triggers
// RULE15 - Long and short low pulse modes
// RULE16 - Termination selects fifty ohm only as input
// RULE17 - First event triggers, re-arm after recording
// RULE18 - Pulse length in sample clocks, 2 to 255
// RULE19 - Illegal divider writes keep previous value
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
module tscd_top (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic ext_clk_i,
    input wire logic trig_in_i,
    input wire logic rec_done_i,
    output logic trig_out_o,
    output logic trig_oe_n_o,
    output logic term_50_o,
    output logic sample_tick_o,
    output logic armed_o,
    output logic recording_o
);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [31:0] board_command;
    logic [10:0] ext_clock_divider;
    logic [31:0] trigger_mode_select;
    logic trigger_connector_direction;
    logic trigger_input_termination;
    logic [7:0] pulse_length_limit;
    tscd_pkg::tscd_state_t state;
    logic [3:0] setup_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave
    logic acc;
    logic wr_pend;
    logic rd_pend;
    logic [17:0] addr_q;
    logic addr_ok;
    logic [15:0] idx_q;
    logic [31:0] next_rdata;
    logic wr_cmd;

    assign acc = hsel_i & htrans_i[1] & hready_i;
    assign idx_q = addr_q[17:2];

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= 18'h00000;
            addr_ok <= 1'b0;
        end else begin
            wr_pend <= acc & hwrite_i;
            rd_pend <= acc & ~hwrite_i;
            if (acc) begin
                addr_q <= haddr_i[17:0];
                addr_ok <= (haddr_i[31:18] == 14'h0000) &&
                           (haddr_i[1:0] == 2'b00);
            end
        end
    end

    // One read wait state keeps hrdata on a flop
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            hrdata_o <= 32'h0000_0000;
        end else begin
            hresp_o <= 1'b0;
            if (acc && !hwrite_i) begin
                hreadyout_o <= 1'b0;
            end else if (rd_pend) begin
                hreadyout_o <= 1'b1;
                hrdata_o <= next_rdata;
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (addr_ok) begin
            case (idx_q)
                tscd_pkg::IDX_BOARD_COMMAND:
                    next_rdata = board_command;
                tscd_pkg::IDX_EXT_CLOCK_DIVIDER:
                    next_rdata = {21'h000000, ext_clock_divider};
                tscd_pkg::IDX_TRIGGER_MODE_SELECT:
                    next_rdata = trigger_mode_select;
                tscd_pkg::IDX_TRIGGER_CONNECTOR_DIRECTION:
                    next_rdata = {31'h00000000, trigger_connector_direction};
                tscd_pkg::IDX_TRIGGER_INPUT_TERMINATION:
                    next_rdata = {31'h00000000, trigger_input_termination};
                tscd_pkg::IDX_PULSE_LENGTH_LIMIT:
                    next_rdata = {24'h000000, pulse_length_limit};
                tscd_pkg::IDX_TRIGGER_STATUS: begin
                    next_rdata[tscd_pkg::STAT_ARMED_BIT] =
                        (state == tscd_pkg::ST_ARMED);
                    next_rdata[tscd_pkg::STAT_SETUP_BIT] =
                        (state == tscd_pkg::ST_SETUP);
                    next_rdata[tscd_pkg::STAT_REC_BIT] =
                        (state == tscd_pkg::ST_REC);
                end
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    function automatic logic hit_reg(input logic [15:0] idx);
        hit_reg = wr_pend && addr_ok && (idx_q == idx);
    endfunction : hit_reg

    assign wr_cmd = hit_reg(tscd_pkg::IDX_BOARD_COMMAND);

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            board_command <= tscd_pkg::RST_BOARD_COMMAND;
        end else if (wr_cmd) begin
            board_command <= hwdata_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ext_clock_divider <= tscd_pkg::RST_EXT_CLOCK_DIVIDER;
        end else if (hit_reg(tscd_pkg::IDX_EXT_CLOCK_DIVIDER) &&
                     tscd_pkg::div_allowed(hwdata_i)) begin
            ext_clock_divider <= hwdata_i[10:0]; // [RULE1] [RULE19]
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            trigger_mode_select <= tscd_pkg::RST_TRIGGER_MODE_SELECT;
            trigger_connector_direction <=
                tscd_pkg::RST_TRIGGER_CONNECTOR_DIRECTION;
            trigger_input_termination <=
                tscd_pkg::RST_TRIGGER_INPUT_TERMINATION;
        end else begin
            if (hit_reg(tscd_pkg::IDX_TRIGGER_MODE_SELECT)) begin
                trigger_mode_select <= hwdata_i;
            end
            if (hit_reg(tscd_pkg::IDX_TRIGGER_CONNECTOR_DIRECTION)) begin
                trigger_connector_direction <= hwdata_i[0];
            end
            if (hit_reg(tscd_pkg::IDX_TRIGGER_INPUT_TERMINATION)) begin
                trigger_input_termination <= hwdata_i[0];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            pulse_length_limit <= tscd_pkg::RST_PULSE_LENGTH_LIMIT;
        end else if (hit_reg(tscd_pkg::IDX_PULSE_LENGTH_LIMIT) &&
                     hwdata_i[31:8] == 24'h000000 &&
                     hwdata_i[7:0] >= tscd_pkg::PULSE_LENGTH_MIN) begin
            pulse_length_limit <= hwdata_i[7:0]; // [RULE18]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample clock
    logic tick;

    tscd_clk_div u_div (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .ext_clk_i(ext_clk_i),
        .div_i(ext_clock_divider),
        .tick_o(tick)
    );

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            sample_tick_o <= 1'b0;
        end else begin
            sample_tick_o <= tick; // [RULE2] [RULE3]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    logic m_free;
    logic m_rise;
    logic m_fall;
    logic m_any;
    logic m_lhi;
    logic m_shi;
    logic m_llo;
    logic m_slo;
    logic m_ext;

    assign m_free = trigger_mode_select == tscd_pkg::FREE_RUN_MODE;
    assign m_rise = trigger_mode_select == tscd_pkg::RISING_EDGE_MODE;
    assign m_fall = trigger_mode_select == tscd_pkg::FALLING_EDGE_MODE;
    assign m_any = trigger_mode_select == tscd_pkg::ANY_EDGE_MODE;
    assign m_lhi = trigger_mode_select == tscd_pkg::LONG_HIGH_PULSE_MODE;
    assign m_shi = trigger_mode_select == tscd_pkg::SHORT_HIGH_PULSE_MODE;
    assign m_llo = trigger_mode_select == tscd_pkg::LONG_LOW_PULSE_MODE;
    assign m_slo = trigger_mode_select == tscd_pkg::SHORT_LOW_PULSE_MODE;
    assign m_ext = m_rise | m_fall | m_any | m_lhi | m_shi | m_llo | m_slo;

    ////////////////////////////////////////////////////////////////////////
    // External trigger detection
    logic trig_q;
    logic rise;
    logic fall;
    logic [7:0] pulse_cnt;
    logic pulse_ok;
    logic pol;
    logic ext_hit;
    logic armed;

    assign armed = state == tscd_pkg::ST_ARMED;
    assign rise = trig_in_i & ~trig_q;
    assign fall = ~trig_in_i & trig_q;
    assign pol = m_lhi | m_shi;

    // Pulse counts start only at edges seen while armed
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            trig_q <= 1'b0;
            pulse_cnt <= 8'h00;
            pulse_ok <= 1'b0;
        end else begin
            trig_q <= trig_in_i;
            if (!armed) begin
                pulse_ok <= 1'b0;
                pulse_cnt <= 8'h00;
            end else if (rise | fall) begin
                pulse_ok <= 1'b1;
                pulse_cnt <= 8'h00;
            end else if (tick && pulse_cnt != 8'hFF) begin
                pulse_cnt <= pulse_cnt + 8'h01; // [RULE18]
            end
        end
    end

    always_comb begin
        ext_hit = 1'b0;
        if (m_rise && rise) begin
            ext_hit = 1'b1; // [RULE10]
        end
        if (m_fall && fall) begin
            ext_hit = 1'b1; // [RULE11]
        end
        if (m_any && (rise | fall)) begin
            ext_hit = 1'b1; // [RULE12]
        end
        if ((m_lhi | m_llo) && pulse_ok && trig_q == pol &&
            trig_in_i == pol && pulse_cnt > pulse_length_limit) begin
            ext_hit = 1'b1; // [RULE13] [RULE15]
        end
        if ((m_shi | m_slo) && pulse_ok && trig_q == pol &&
            trig_in_i != pol && pulse_cnt < pulse_length_limit) begin
            ext_hit = 1'b1; // [RULE14] [RULE15]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Acquisition sequence
    logic cmd_start;
    logic cmd_stop;
    logic cmd_force;

    assign cmd_start = wr_cmd && hwdata_i == tscd_pkg::CMD_START;
    assign cmd_stop = wr_cmd && hwdata_i == tscd_pkg::CMD_STOP;
    assign cmd_force = wr_cmd && hwdata_i == tscd_pkg::FORCE_TRIGGER_CMD;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state <= tscd_pkg::ST_IDLE;
            setup_cnt <= 4'h0;
        end else if (cmd_stop) begin
            state <= tscd_pkg::ST_IDLE;
        end else begin
            case (state)
                tscd_pkg::ST_IDLE: begin
                    setup_cnt <= 4'h0;
                    if (cmd_start) begin
                        state <= m_free ? tscd_pkg::ST_SETUP
                                        : tscd_pkg::ST_ARMED;
                    end
                end
                tscd_pkg::ST_SETUP: begin
                    if (setup_cnt == tscd_pkg::SETUP_CNT_LAST) begin
                        state <= tscd_pkg::ST_REC; // [RULE4]
                    end else begin
                        setup_cnt <= setup_cnt + 4'h1;
                    end
                end
                tscd_pkg::ST_ARMED: begin
                    if (cmd_force || (m_ext && ext_hit)) begin
                        state <= tscd_pkg::ST_REC; // [RULE5] [RULE17]
                    end
                end
                tscd_pkg::ST_REC: begin
                    setup_cnt <= 4'h0;
                    if (rec_done_i) begin
                        state <= m_free ? tscd_pkg::ST_SETUP
                                        : tscd_pkg::ST_ARMED; // [RULE17]
                    end
                end
                default: state <= tscd_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Connector driver and termination
    logic drive;
    logic rec_next;

    assign drive = !m_ext && trigger_connector_direction; // [RULE6] [RULE9]
    assign rec_next = (state == tscd_pkg::ST_REC);

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            trig_oe_n_o <= 1'b1;
            trig_out_o <= 1'b0;
            term_50_o <= 1'b0;
            armed_o <= 1'b0;
            recording_o <= 1'b0;
        end else begin
            trig_oe_n_o <= ~drive; // [RULE6] [RULE7] [RULE9]
            trig_out_o <= drive & rec_next; // [RULE7] [RULE8]
            term_50_o <= trigger_input_termination & ~drive; // [RULE16]
            armed_o <= armed;
            recording_o <= rec_next;
        end
    end

endmodule : tscd_top

// file: testbench/tscd_top_sva.sv
// Port assertions for the trigger select block
`timescale 1ns/1ps
module tscd_top_chk (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic rec_done_i,
    input wire logic trig_out_o,
    input wire logic trig_oe_n_o,
    input wire logic term_50_o,
    input wire logic armed_o,
    input wire logic recording_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);

    ////////////////////////////////////////////////////////////////////////
    // Bus sequences
    sequence s_req;
        hsel_i && htrans_i[1] && hready_i;
    endsequence
    sequence s_rd_answer;
        !hreadyout_o ##1 hreadyout_o;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // Properties
    a_read_wait: assert property (s_req and !hwrite_i |=> s_rd_answer)
        else $error("read timing");
    a_write_zero: assert property (s_req and hwrite_i |=> hreadyout_o)
        else $error("write stalled");
    a_resp_okay: assert property (!hresp_o)
        else $error("error resp");
    a_term_input: assert property (!trig_oe_n_o |-> !term_50_o)
        else $error("term while driven");
    a_out_driven: assert property (trig_out_o |-> !trig_oe_n_o)
        else $error("trigger undriven");
    a_out_marks: assert property (trig_out_o |-> recording_o)
        else $error("trigger off record");
    a_arm_excl: assert property (!(armed_o && recording_o))
        else $error("armed in record");
    a_rec_done: assert property
        (recording_o && rec_done_i |-> ##[1:2] !recording_o)
        else $error("record after done");
    a_reset_out: assert property (disable iff (1'b0) srst_i |=>
        trig_oe_n_o && !armed_o && !recording_o && !trig_out_o)
        else $error("reset outputs");
endmodule : tscd_top_chk

bind tscd_top tscd_top_chk u_chk (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .rec_done_i(rec_done_i), .trig_out_o(trig_out_o),
    .trig_oe_n_o(trig_oe_n_o), .term_50_o(term_50_o), .armed_o(armed_o),
    .recording_o(recording_o));

// file: testbench/tscd_ext_model.sv
// Far side: external clock source and trigger connector
`timescale 1ns/1ps
module tscd_ext_model (
    input wire logic clk_sys_i,
    input wire logic trig_out_i,
    input wire logic trig_oe_n_i,
    output logic ext_clk_o,
    output logic line_o
);
    logic src_lvl = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Free running 50 MHz clock
    initial begin
        ext_clk_o = 1'b0;
        #3;
        forever #10 ext_clk_o = ~ext_clk_o;
    end

    // Device driver wins when enabled
    assign line_o = trig_oe_n_i ? src_lvl : trig_out_i;

    task automatic drive(input logic lvl);
        @(posedge clk_sys_i);
        src_lvl <= lvl;
    endtask : drive
endmodule : tscd_ext_model

// file: testbench/test_trigger_select_and_clock_divider.sv
// Testbench for the trigger select and clock divider
`timescale 1ns/1ps
module test_trigger_select_and_clock_divider;
    localparam logic [15:0] A_CMD = tscd_pkg::IDX_BOARD_COMMAND,
        A_DIV = tscd_pkg::IDX_EXT_CLOCK_DIVIDER,
        A_MODE = tscd_pkg::IDX_TRIGGER_MODE_SELECT,
        A_DIR = tscd_pkg::IDX_TRIGGER_CONNECTOR_DIRECTION,
        A_TERM = tscd_pkg::IDX_TRIGGER_INPUT_TERMINATION,
        A_PLEN = tscd_pkg::IDX_PULSE_LENGTH_LIMIT;
    logic clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0,
        rec_done = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rdata;
    logic rdy, resp, ext_clk, line, trig_out, oe_n, term, tick, armed, rec;
    int failures = 0, checks = 0;

    tscd_top dut (.clk_sys_i(clk), .srst_i(srst), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(rdy),
        .hreadyout_o(rdy), .hresp_o(resp), .hrdata_o(rdata),
        .ext_clk_i(ext_clk), .trig_in_i(line), .rec_done_i(rec_done),
        .trig_out_o(trig_out), .trig_oe_n_o(oe_n), .term_50_o(term),
        .sample_tick_o(tick), .armed_o(armed), .recording_o(rec));
    tscd_ext_model peer (.clk_sys_i(clk), .trig_out_i(trig_out),
        .trig_oe_n_i(oe_n), .ext_clk_o(ext_clk), .line_o(line));

    initial begin
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic end_sim();
        if (failures == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic chk1(input logic g, input logic e);
        check({31'h0, g}, {31'h0, e});
    endtask : chk1

    task automatic bus(input logic w, input logic [15:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {14'h0, idx, 2'h0};
        do @(posedge clk); while (rdy !== 1'b1 && ++n < 20);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (rdy !== 1'b1 && ++n < 40);
        rd = rdata;
        chk1(n < 20, 1'b1);
    endtask : bus

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, idx, d, unused);
    endtask : wr

    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 32'h0, d);
        check(d, exp);
    endtask : rd_chk

    task automatic wait_st(input logic use_rec, input logic v, input int lim);
        int n;
        n = 0;
        do @(posedge clk); while (((use_rec ? rec : armed) !== v) && ++n < lim);
        chk1(n < lim, 1'b1);
    endtask : wait_st

    task automatic start(input logic [31:0] mode);
        wr(A_MODE, mode);
        wr(A_CMD, tscd_pkg::CMD_START);
    endtask : start

    task automatic stop();
        wr(A_CMD, tscd_pkg::CMD_STOP);
        wait_st(1'b1, 1'b0, 4);
    endtask : stop

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs();
        rd_chk(A_DIV, 32'h1);
        rd_chk(A_MODE, 32'h0);
        rd_chk(A_DIR, 32'h0);
        rd_chk(A_TERM, 32'h0);
        rd_chk(A_PLEN, 32'h2);
        rd_chk(16'h0100, 32'h0);
    endtask : t_regs

    task automatic t_divider();
        logic [31:0] divs [17] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'hA,
            32'h10, 32'h14, 32'h28, 32'h32, 32'h50, 32'h64, 32'hC8,
            32'h190, 32'h1F4, 32'h320, 32'h3E8, 32'h7D0};
        int n;
        for (int i = 0; i < 17; i++) begin
            wr(A_DIV, divs[i]);
            rd_chk(A_DIV, divs[i]);
        end
        wr(A_DIV, 32'h3);
        rd_chk(A_DIV, 32'h7D0);
        for (int k = 0; k < 2; k++) begin
            wr(A_DIV, k ? 32'h1 : 32'h4);
            n = 0;
            repeat (160) begin
                @(posedge clk);
                if (tick === 1'b1) n++;
            end
            chk1(n >= (k ? 39 : 9) && n <= (k ? 41 : 11), 1'b1);
        end
    endtask : t_divider

    task automatic t_edges();
        logic [31:0] m [4] = '{tscd_pkg::RISING_EDGE_MODE,
            tscd_pkg::FALLING_EDGE_MODE, tscd_pkg::ANY_EDGE_MODE,
            tscd_pkg::ANY_EDGE_MODE};
        logic init [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        logic first [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
        logic lvl;
        wr(A_DIR, 32'h1);
        wr(A_TERM, 32'h1);
        for (int i = 0; i < 4; i++) begin
            peer.drive(init[i]);
            start(m[i]);
            wait_st(1'b0, 1'b1, 4);
            chk1(oe_n, 1'b1);
            chk1(term, 1'b1);
            lvl = ~init[i];
            peer.drive(lvl);
            repeat (4) @(posedge clk);
            chk1(rec, first[i]);
            if (!first[i]) begin
                lvl = ~lvl;
                peer.drive(lvl);
                wait_st(1'b1, 1'b1, 5);
            end
            peer.drive(~lvl);
            repeat (4) @(posedge clk);
            chk1(rec, 1'b1);
            rec_done <= 1'b1;
            @(posedge clk) rec_done <= 1'b0;
            wait_st(1'b0, 1'b1, 4);
            peer.drive(lvl);
            wait_st(1'b1, 1'b1, 5);
            stop();
        end
    endtask : t_edges

    task automatic t_free_run();
        wr(A_DIR, 32'h1);
        start(tscd_pkg::FREE_RUN_MODE);
        repeat (3) @(posedge clk);
        chk1(rec, 1'b0);
        wait_st(1'b1, 1'b1, 6);
        chk1(trig_out, 1'b1);
        chk1(oe_n, 1'b0);
        chk1(term, 1'b0);
        wr(A_CMD, tscd_pkg::FORCE_TRIGGER_CMD);
        chk1(rec, 1'b1);
        rec_done <= 1'b1;
        @(posedge clk) rec_done <= 1'b0;
        wait_st(1'b1, 1'b0, 4);
        wait_st(1'b1, 1'b1, 8);
        stop();
        wr(A_DIR, 32'h0);
        wr(A_CMD, tscd_pkg::CMD_START);
        wait_st(1'b1, 1'b1, 8);
        chk1(oe_n, 1'b1);
        chk1(trig_out, 1'b0);
        stop();
    endtask : t_free_run

    task automatic t_force();
        peer.drive(1'b0);
        wr(A_MODE, tscd_pkg::RISING_EDGE_MODE);
        wr(A_CMD, tscd_pkg::FORCE_TRIGGER_CMD);
        repeat (4) @(posedge clk);
        chk1(rec, 1'b0);
        wr(A_CMD, tscd_pkg::CMD_START);
        wait_st(1'b0, 1'b1, 4);
        wr(A_CMD, tscd_pkg::FORCE_TRIGGER_CMD);
        wait_st(1'b1, 1'b1, 4);
        stop();
    endtask : t_force

    task automatic t_pulse();
        logic [31:0] m [4] = '{tscd_pkg::LONG_HIGH_PULSE_MODE,
            tscd_pkg::SHORT_HIGH_PULSE_MODE, tscd_pkg::LONG_LOW_PULSE_MODE,
            tscd_pkg::SHORT_LOW_PULSE_MODE};
        logic idle [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
        logic lng [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        wr(A_PLEN, 32'h1);
        rd_chk(A_PLEN, 32'h2);
        wr(A_PLEN, 32'h3);
        rd_chk(A_PLEN, 32'h3);
        for (int i = 0; i < 4; i++) begin
            peer.drive(idle[i]);
            start(m[i]);
            wait_st(1'b0, 1'b1, 4);
            for (int p = 0; p < 2; p++) begin
                peer.drive(~idle[i]);
                repeat ((lng[i] ^ p[0]) ? 6 : 40) @(posedge clk);
                peer.drive(idle[i]);
                repeat (8) @(posedge clk);
                chk1(rec, p[0]);
            end
            stop();
        end
    endtask : t_pulse

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_divider();
        t_edges();
        t_free_run();
        t_force();
        t_pulse();
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim();
    end
endmodule : test_trigger_select_and_clock_divider
